// file: ebw_defines.svh
// Purpose: Constants of the external bus window controller
// Assumes: Included by bare name wherever a field or area is needed
// Notes: Definitions only
`ifndef EBW_DEFINES_SVH
`define EBW_DEFINES_SVH

// Linear space: 16 Mbytes, 64-Kbyte segments, 16-Kbyte pages
`define EBW_ADDR_W 24
`define EBW_SEG_BITS 16
`define EBW_PAGE_BITS 14
`define EBW_DATA_W 16

// Address windows and regions (region 0 is the default region)
`define EBW_NUM_WIN 4
`define EBW_NUM_REG 5
`define EBW_REG_W 3
`define EBW_WIN_LSB 12
`define EBW_WIN_W 12

// Region timing config fields
`define EBW_TC_W 8
`define EBW_TC_ADDR_MSB 1
`define EBW_TC_ADDR_LSB 0
`define EBW_TC_ACC_MSB 5
`define EBW_TC_ACC_LSB 2
`define EBW_TC_REC_MSB 7
`define EBW_TC_REC_LSB 6

// Region function config bits
`define EBW_FC_W 5
`define EBW_FC_RDY_EN 0
`define EBW_FC_RDY_HI 1
`define EBW_FC_BUS16 2
`define EBW_FC_DEMUX 3
`define EBW_FC_CS_EN 4

// Fixed areas
`define EBW_SEG_PERIPH 8'h20
`define EBW_IO_LO 24'h210000
`define EBW_IO_HI 24'h3fffff

// Reset values
`define EBW_CS_IDLE 5'h1f

`endif

// file: ebw_pkg.sv
// Purpose: Types of the external bus window controller
// Assumes: Nothing beyond the defines header
// Notes: Constants live in ebw_defines.svh
`include "ebw_defines.svh"
package ebw_pkg;
   typedef logic [`EBW_ADDR_W-1:0] ebw_addr_type;
   typedef logic [`EBW_DATA_W-1:0] ebw_data_type;
   typedef enum logic [2:0] {
      EBW_IDLE,
      EBW_ADDR,
      EBW_ACC,
      EBW_WAIT,
      EBW_RECOV
   } ebw_state_type;
endpackage

// file: ebw_sync.sv
// Purpose: Two-flop synchroniser with change detect behind it
// Assumes: Input is a level or a toggle from another domain
// Notes: chg_o looks at flops two and three only
`timescale 1ns/1ps
module ebw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Asynchronous input
   input wire logic [W-1:0] d_i,
   // Synchronised level and change pulse
   output logic [W-1:0] q_o,
   output logic chg_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Shift chain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Outputs from the settled flops
   assign q_o = s2_q;
   assign chg_o = |(s2_q ^ s3_q);
endmodule

// file: ebw_ctrl.sv
// Purpose: External bus window controller, request side and bus side
// Assumes: Config ports are static while a cycle is in flight
// Notes: Bus logic runs on link_clk_i; handshake by toggles
`timescale 1ns/1ps
`include "ebw_defines.svh"
// What this block does
// - Decode 16-Mbyte space as 256 segments of four 16-Kbyte pages.
// - Every address reachable with byte or word accesses.
// - Reserved areas are forwarded as external bus cycles.
// - External IO area accesses hold the pipeline for strict order.
// - Single-chip setting refuses external cycles; external setting runs them.
// - Driven address-line bits selectable from zero to twenty-three; mux AD always carries the low sixteen.
// - External data path eight or sixteen bits wide.
// - Multiplexed or demultiplexed; demux puts low address on own lines.
// - Selectable segment line count limits space from 8M to 64K.
// - One chip select per window plus one for the default region.
// - Timing and function configuration held per chip-select region.
// - Ready input extends cycles; its active level is selectable.
// - Four windows; window four beats three, two beats one.
// - Addresses matching no window use the default region settings.
// - Selected window may assert its chip select.
// - Bus timing referenced to rising edge of reference clock out.
// - Bus mode switches per access from the matched window.
// - Internal peripheral bus accesses served like external targets.
module ebw_ctrl (
   // Core clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bus link clock
   input wire logic link_clk_i,
   // Request port
   input wire logic req_i,
   input wire ebw_pkg::ebw_addr_type req_addr_i,
   input wire logic req_wr_i,
   input wire logic req_byte_i,
   input wire ebw_pkg::ebw_data_type req_wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic err_o,
   output ebw_pkg::ebw_data_type rdata_o,
   output logic pipe_hold_o,
   // Global configuration
   input wire logic ext_mode_i,
   input wire logic [4:0] addr_width_i,
   input wire logic [2:0] seg_lines_i,
   // Window address select
   input wire logic [`EBW_NUM_WIN-1:0] win_en_i,
   input wire logic [`EBW_NUM_WIN-1:0][`EBW_WIN_W-1:0] win_base_i,
   input wire logic [`EBW_NUM_WIN-1:0][`EBW_WIN_W-1:0] win_mask_i,
   // Region timing and function config
   input wire logic [`EBW_NUM_REG-1:0][`EBW_TC_W-1:0] region_timing_i,
   input wire logic [`EBW_NUM_REG-1:0][`EBW_FC_W-1:0] region_function_i,
   // External bus pins
   output logic bus_reference_clock_out_o,
   output ebw_pkg::ebw_addr_type addr_o,
   output ebw_pkg::ebw_addr_type addr_en_o,
   input wire ebw_pkg::ebw_data_type ad_i,
   output ebw_pkg::ebw_data_type ad_o,
   output logic ad_oe_o,
   output logic ale_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic bhe_n_o,
   output logic [`EBW_NUM_REG-1:0] cs_n_o,
   input wire logic ready_i,
   // Internal peripheral bus
   output logic ipb_sel_o,
   output logic ipb_wr_o,
   output ebw_pkg::ebw_addr_type ipb_addr_o,
   output ebw_pkg::ebw_data_type ipb_wdata_o,
   input wire ebw_pkg::ebw_data_type ipb_rdata_i,
   input wire logic ipb_rdy_i
);
   import ebw_pkg::*;

   // Driven address bits: below width and below segment line limit
   function automatic ebw_addr_type drv_mask(input logic [4:0] w,
                                             input logic [2:0] s);
      ebw_addr_type m;
      m = '0;
      for (int i = 0; i < `EBW_ADDR_W; i++) begin
         m[i] = (i < int'(w)) && (i < `EBW_SEG_BITS + int'(s));
      end
      return m;
   endfunction

   // ---------------- Core domain ----------------
   logic busy_q, done_q, err_q, pipe_hold_q, req_tgl_q;
   ebw_data_type rdata_q, h_wdata_q;
   ebw_addr_type h_addr_q, h_mask_q;
   logic h_wr_q, h_byte_q, h_ipb_q;
   logic [`EBW_REG_W-1:0] h_reg_q;
   logic [`EBW_TC_W-1:0] h_tc_q;
   logic [`EBW_FC_W-1:0] h_fc_q;
   logic done_pulse;
   logic [`EBW_NUM_WIN-1:0] win_hit;
   logic [`EBW_REG_W-1:0] reg_sel;
   logic [7:0] seg;
   logic [1:0] page;
   logic is_ipb, is_io, accept, refuse, go;
   ebw_data_type l_rdata_q;
   logic done_tgl_q;

   // Window match per window
   genvar gi;
   generate
      for (gi = 0; gi < `EBW_NUM_WIN; gi++) begin : g_win
         assign win_hit[gi] = win_en_i[gi] &&
            ((req_addr_i[`EBW_ADDR_W-1:`EBW_WIN_LSB] & win_mask_i[gi]) ==
             (win_base_i[gi] & win_mask_i[gi]));
      end
   endgenerate

   // Region priority, then area decode by segment and by IO address range
   assign reg_sel = win_hit[3] ? 3'h4 : win_hit[2] ? 3'h3 :
                    win_hit[1] ? 3'h2 : win_hit[0] ? 3'h1 :
                    3'h0;
   assign seg = req_addr_i[`EBW_ADDR_W-1:`EBW_SEG_BITS];
   assign page = req_addr_i[`EBW_SEG_BITS-1:`EBW_PAGE_BITS];
   assign is_ipb = (seg == `EBW_SEG_PERIPH);
   assign is_io = (req_addr_i >= `EBW_IO_LO) && (req_addr_i <= `EBW_IO_HI);
   // Everything else, reserved areas too, goes out on the bus
   assign accept = req_i && !busy_q;
   assign refuse = accept && !is_ipb && !ext_mode_i;
   assign go = accept && !refuse;

   // Request capture and toggle launch
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
         req_tgl_q <= 1'b0;
         h_addr_q <= '0;
         h_wdata_q <= '0;
         h_wr_q <= 1'b0;
         h_byte_q <= 1'b0;
         h_ipb_q <= 1'b0;
         h_reg_q <= '0;
         h_tc_q <= '0;
         h_fc_q <= '0;
         h_mask_q <= '0;
      end else if (go) begin
         busy_q <= 1'b1;
         req_tgl_q <= ~req_tgl_q;
         h_addr_q <= req_addr_i;
         h_wdata_q <= req_wdata_i;
         h_wr_q <= req_wr_i;
         h_byte_q <= req_byte_i;
         h_ipb_q <= is_ipb;
         h_reg_q <= reg_sel;
         h_tc_q <= region_timing_i[reg_sel];
         h_fc_q <= region_function_i[reg_sel];
         h_mask_q <= drv_mask(addr_width_i, seg_lines_i);
      end else if (done_pulse) begin
         busy_q <= 1'b0;
      end
   end

   // Answer and pipeline hold
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= '0;
         pipe_hold_q <= 1'b0;
      end else begin
         done_q <= refuse || done_pulse;
         err_q <= refuse;
         rdata_q <= done_pulse ? l_rdata_q : rdata_q;
         pipe_hold_q <= (go && is_io) || (pipe_hold_q && !done_pulse);
      end
   end

   // Completion toggle back from the link domain
   ebw_sync #(.W(1)) u_done_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(done_tgl_q),
      .q_o(),
      .chg_o(done_pulse)
   );

   assign busy_o = busy_q;
   assign done_o = done_q;
   assign err_o = err_q;
   assign rdata_o = rdata_q;
   assign pipe_hold_o = pipe_hold_q;
   assign ipb_wdata_o = h_wdata_q;

   // ---------------- Link domain ----------------
   ebw_state_type st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic rclk_q, pend_q, beat_q, cap_q;
   logic [`EBW_NUM_REG-1:0] cs_n_q, cs_vec;
   logic ale_q, rd_n_q, wr_n_q, bhe_n_q, ad_oe_q, ipb_sel_q, ipb_wr_q;
   ebw_addr_type a_q, a_en_q, la_q, ba;
   ebw_data_type ad_q, ad_s, wdrive, rd_in, rnext;
   logic req_pulse, rdy_s, rdy_ok, tick, cnt0, ext, wide, two_beat;
   logic enter_addr, enter_acc, fin, end_rec, last;
   logic f_rdy_en, f_rdy_hi, f_bus16, f_demux, f_cs_en;
   logic [7:0] wbyte;

   ebw_sync #(.W(1)) u_req_sync (
      .clk_i(link_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(req_tgl_q),
      .q_o(),
      .chg_o(req_pulse)
   );
   ebw_sync #(.W(1)) u_rdy_sync (
      .clk_i(link_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(ready_i),
      .q_o(rdy_s),
      .chg_o()
   );
   ebw_sync #(.W(`EBW_DATA_W)) u_ad_sync (
      .clk_i(link_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(ad_i),
      .q_o(ad_s),
      .chg_o()
   );

   // Held region settings, stable while a request is pending
   assign f_rdy_en = h_fc_q[`EBW_FC_RDY_EN];
   assign f_rdy_hi = h_fc_q[`EBW_FC_RDY_HI];
   assign f_bus16 = h_fc_q[`EBW_FC_BUS16];
   assign f_demux = h_fc_q[`EBW_FC_DEMUX];
   assign f_cs_en = h_fc_q[`EBW_FC_CS_EN];
   assign ext = !h_ipb_q;
   assign wide = f_bus16 || h_ipb_q;
   assign two_beat = !h_byte_q && !wide;
   assign ba = {h_addr_q[`EBW_ADDR_W-1:1], h_addr_q[0] | beat_q};
   assign cs_vec = (f_cs_en && ext) ? ~(5'h01 << h_reg_q) : `EBW_CS_IDLE;

   // Write lanes and read assembly
   assign wbyte = (h_byte_q || !beat_q) ? h_wdata_q[7:0] : h_wdata_q[15:8];
   assign wdrive = f_bus16 ? (h_byte_q ? {h_wdata_q[7:0], h_wdata_q[7:0]}
                                       : h_wdata_q)
                           : {8'h00, wbyte};
   assign rd_in = h_ipb_q ? ipb_rdata_i : ad_s;
   assign rnext = wide ? (h_byte_q ? {8'h00, ba[0] ? rd_in[15:8] : rd_in[7:0]}
                                   : rd_in)
                       : (beat_q ? {rd_in[7:0], l_rdata_q[7:0]}
                                 : {8'h00, rd_in[7:0]});

   // Ready at its selected level; peripheral bus uses its own ready
   assign rdy_ok = h_ipb_q ? ipb_rdy_i
                           : (!f_rdy_en || (rdy_s == f_rdy_hi));

   // Phase events, all on the cycle before a reference clock rise
   assign tick = !rclk_q;
   assign cnt0 = (cnt_q == 4'h0);
   assign enter_addr = tick && (st_q == EBW_IDLE) && pend_q;
   assign enter_acc = tick && (st_q == EBW_ADDR) && cnt0;
   assign fin = tick && rdy_ok &&
                (((st_q == EBW_ACC) && cnt0) || (st_q == EBW_WAIT));
   assign end_rec = tick && (st_q == EBW_RECOV) && cnt0;
   assign last = end_rec && (!two_beat || beat_q);

   // Phase sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         EBW_IDLE: begin
            if (enter_addr) begin
               st_d = EBW_ADDR;
               cnt_d = {2'b00, h_tc_q[`EBW_TC_ADDR_MSB:`EBW_TC_ADDR_LSB]};
            end
         end
         EBW_ADDR: begin
            if (enter_acc) begin
               st_d = EBW_ACC;
               cnt_d = h_tc_q[`EBW_TC_ACC_MSB:`EBW_TC_ACC_LSB];
            end else if (tick) begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         EBW_ACC: begin
            if (fin) begin
               st_d = EBW_RECOV;
               cnt_d = {2'b00, h_tc_q[`EBW_TC_REC_MSB:`EBW_TC_REC_LSB]};
            end else if (tick && cnt0) begin
               st_d = EBW_WAIT;
            end else if (tick) begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         EBW_WAIT: begin
            if (fin) begin
               st_d = EBW_RECOV;
               cnt_d = {2'b00, h_tc_q[`EBW_TC_REC_MSB:`EBW_TC_REC_LSB]};
            end
         end
         EBW_RECOV: begin
            if (end_rec) begin
               st_d = EBW_IDLE;
            end else if (tick) begin
               cnt_d = cnt_q - 4'h1;
            end
         end
      endcase
   end

   // Sequencer state, reference clock and handshake
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= EBW_IDLE;
         cnt_q <= 4'h0;
         rclk_q <= 1'b0;
         pend_q <= 1'b0;
         beat_q <= 1'b0;
         done_tgl_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rclk_q <= ~rclk_q;
         pend_q <= req_pulse || (pend_q && !last);
         beat_q <= !last && (beat_q || end_rec);
         done_tgl_q <= done_tgl_q ^ last;
      end
   end

   // Chip selects, latch enable and strobes
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_n_q <= `EBW_CS_IDLE;
         ale_q <= 1'b0;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         bhe_n_q <= 1'b1;
      end else begin
         cs_n_q <= enter_addr ? cs_vec : (end_rec ? `EBW_CS_IDLE : cs_n_q);
         ale_q <= enter_addr ? (ext && !f_demux) : (ale_q && !enter_acc);
         rd_n_q <= (enter_acc && ext && !h_wr_q) ? 1'b0 : (rd_n_q || fin);
         wr_n_q <= (enter_acc && ext && h_wr_q) ? 1'b0 : (wr_n_q || fin);
         bhe_n_q <= enter_addr ? !(ext && f_bus16 && (!h_byte_q || ba[0]))
                               : (bhe_n_q || end_rec);
      end
   end

   // Address and data lines, read capture, peripheral bus
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_q <= '0;
         a_en_q <= '0;
         ad_q <= '0;
         ad_oe_q <= 1'b0;
         ipb_sel_q <= 1'b0;
         ipb_wr_q <= 1'b0;
         la_q <= '0;
         l_rdata_q <= '0;
         cap_q <= 1'b0;
      end else begin
         cap_q <= fin && ext && !h_wr_q;
         if (enter_addr) begin
            a_q <= ba & h_mask_q;
            a_en_q <= !ext ? '0 : f_demux ? h_mask_q
                      : (h_mask_q & 24'hff0000);
            ad_q <= ba[15:0];
            ad_oe_q <= ext && !f_demux;
            ipb_sel_q <= h_ipb_q;
            ipb_wr_q <= h_wr_q;
            la_q <= ba;
         end else if (enter_acc) begin
            ad_q <= wdrive;
            ad_oe_q <= ext && h_wr_q;
         end else if (fin) begin
            ad_oe_q <= 1'b0;
            ipb_sel_q <= 1'b0;
            l_rdata_q <= (h_wr_q || ext) ? l_rdata_q : rnext;
         end else if (last) begin
            a_en_q <= '0;
         end else if (cap_q) begin
            // Pin data taken one edge late, once the synchroniser has it
            l_rdata_q <= rnext;
         end
      end
   end

   assign bus_reference_clock_out_o = rclk_q;
   assign addr_o = a_q;
   assign addr_en_o = a_en_q;
   assign ad_o = ad_q;
   assign ad_oe_o = ad_oe_q;
   assign ale_o = ale_q;
   assign rd_n_o = rd_n_q;
   assign wr_n_o = wr_n_q;
   assign bhe_n_o = bhe_n_q;
   assign cs_n_o = cs_n_q;
   assign ipb_sel_o = ipb_sel_q;
   assign ipb_wr_o = ipb_wr_q;
   assign ipb_addr_o = la_q;

   // Checks, core domain
   single_chip_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      refuse |=> done_q && err_q && !busy_q)
      else $error("single-chip refusal not answered");
   win_prio_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      go && win_hit[3] |=> h_reg_q == 3'h4)
      else $error("window four lost priority");
   win_two_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      go && win_hit[1] && !win_hit[2] && !win_hit[3] |=> h_reg_q == 3'h2)
      else $error("window two lost over window one");
   default_reg_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      go && (win_hit == '0) |=> h_reg_q == 3'h0 && h_tc_q == $past(region_timing_i[0]))
      else $error("unmatched access not on default region");
   io_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      go && is_io |=> pipe_hold_q [*2])
      else $error("pipeline hold missing for IO area");

   // Checks, link domain
   sequence s_start;
      tick && (st_q == EBW_IDLE) && pend_q;
   endsequence
   sequence s_stalled;
      tick && (st_q == EBW_WAIT) && !rdy_ok;
   endsequence
   cs_onehot_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      $onehot0(~cs_n_q))
      else $error("several chip selects active");
   idle_cs_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      st_q == EBW_IDLE |-> &cs_n_q)
      else $error("chip select held between cycles");
   ref_toggle_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      rclk_q != $past(rclk_q) || !$past(rst_n_i))
      else $error("reference clock stopped");
   strobe_rise_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      $changed(rd_n_q) || $changed(wr_n_q) || $changed(ale_q) |-> rclk_q)
      else $error("bus phase not on reference rise");
   mux_addr_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      s_start ##0 (ext && !f_demux) |=> ale_q && ad_oe_q ##1 ale_q)
      else $error("multiplexed address phase missing");
   ready_hold_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      s_stalled |=> st_q == EBW_WAIT && $stable(rd_n_q) && $stable(wr_n_q))
      else $error("cycle ended without ready");
   ready_level_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_n_i)
      tick && st_q == EBW_ACC && cnt0 && ext && f_rdy_en &&
      (rdy_s != f_rdy_hi) |=> st_q == EBW_WAIT)
      else $error("inactive ready level ignored");
endmodule

// file: ebw_mem_model.sv
// Purpose: Memory and peripheral partner on the far side of the bus
// Assumes: Byte memory indexed by the low address byte
// Notes: Bus sampled at the falling reference clock, mid-phase
`timescale 1ns/1ps
module ebw_mem_model (
   // Bus pins from the controller
   input wire logic ref_clk_i,
   input wire logic [23:0] addr_i,
   input wire logic [23:0] addr_en_i,
   input wire logic [15:0] ad_i,
   input wire logic ale_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic bhe_n_i,
   // Behaviour chosen by the bench
   input wire logic narrow_i,
   input wire logic rdy_hi_i,
   input wire logic [3:0] wait_i,
   // Answers on the bus
   output logic [15:0] ad_o,
   output logic ready_o,
   // Internal peripheral bus
   input wire logic ipb_sel_i,
   input wire logic [23:0] ipb_addr_i,
   output logic [15:0] ipb_rdata_o,
   output logic ipb_rdy_o
);
   logic [7:0] mem [0:255];
   logic [7:0] a_q;
   logic [3:0] cnt_q = 4'h0;
   logic [15:0] dat;
   // Both lanes valid so either bus width finds its byte
   assign dat = {mem[a_q | 8'h01], mem[a_q]};
   assign ad_o = rd_n_i ? ~dat : dat; // Released bus shows the inverse
   // Ready reaches the chosen level after wait_i strobe ticks
   assign ready_o = (cnt_q >= wait_i) ? rdy_hi_i : ~rdy_hi_i;
   // Peripheral answers with a pattern tied to its address
   assign ipb_rdata_o = ipb_sel_i ? {8'h5a, ipb_addr_i[7:0]} : 16'ha5a5;
   assign ipb_rdy_o = ipb_sel_i;
   // Address latch, wait count and write capture between rising edges
   always @(negedge ref_clk_i) begin
      if (ale_i) a_q <= ad_i[7:0];
      else if (addr_en_i[0]) a_q <= addr_i[7:0];
      cnt_q <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_q + 4'h1;
      if (!wr_n_i && (narrow_i || !a_q[0])) mem[a_q] <= ad_i[7:0];
      if (!wr_n_i && !narrow_i && a_q[0]) mem[a_q] <= ad_i[15:8];
      if (!wr_n_i && !narrow_i && !a_q[0] && !bhe_n_i) begin
         mem[a_q | 8'h01] <= ad_i[15:8];
      end
   end
endmodule

// file: tb.sv
// Purpose: Self-checking bench of the bus window controller
// Assumes: Four windows and five regions as set up at time zero
// Notes: Rows hold plain accesses; hand tests follow the loop
`timescale 1ns/1ps
module tb;
   import ebw_pkg::*;
   typedef struct packed {
      logic [23:0] a;
      logic wr;
      logic by;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [4:0] cs;
      logic ph;
      logic rh;
      logic [3:0] wt;
      logic nr;
      logic [3:0] mn;
   } ebw_tb_row_type;
   logic clk, link_clk, rst_n, req, req_wr, req_byte, busy, done, err;
   logic pipe_hold, ext_mode, refclk, ad_oe, ale, rd_n, wr_n, bhe_n, ready;
   logic ipb_sel, ipb_wr, ipb_rdy, narrow, rdy_hi, ph_seen, e;
   logic [4:0] addr_width, cs_n, cs_seen;
   logic [2:0] seg_lines;
   logic [3:0] win_en, wt;
   logic [3:0][11:0] win_base, win_mask;
   logic [4:0][7:0] region_timing;
   logic [4:0][4:0] region_function;
   ebw_addr_type req_addr, addr, addr_en, ipb_addr, aen_seen;
   ebw_data_type req_wdata, rdata, ad_in, ad_out, ipb_wdata, ipb_rdata, rd;
   int error_cnt = 0;
   int n_tests = 0;
   int stb_cnt = 0;
   ebw_tb_row_type rows [18] = '{
      '{24'h000010,1'h1,1'h0,16'h1234,16'h0,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'h000010,1'h0,1'h0,16'h0,16'h1234,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'h000011,1'h0,1'h1,16'h0,16'h0012,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'h000011,1'h1,1'h1,16'h0077,16'h0,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'h000010,1'h0,1'h0,16'h0,16'h7734,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'h400021,1'h1,1'h1,16'h00ab,16'h0,5'h02,1'h0,1'h0,4'h0,1'h1,4'h1},
      '{24'h400030,1'h1,1'h0,16'hbeef,16'h0,5'h02,1'h0,1'h0,4'h0,1'h1,4'h2},
      '{24'h400030,1'h0,1'h0,16'h0,16'hbeef,5'h02,1'h0,1'h0,4'h0,1'h1,4'h2},
      '{24'h400021,1'h0,1'h1,16'h0,16'h00ab,5'h02,1'h0,1'h0,4'h0,1'h1,4'h1},
      '{24'h410040,1'h1,1'h0,16'hcafe,16'h0,5'h04,1'h0,1'h1,4'h3,1'h0,4'h3},
      '{24'h410040,1'h0,1'h0,16'h0,16'hcafe,5'h04,1'h0,1'h1,4'h3,1'h0,4'h3},
      '{24'h500050,1'h1,1'h0,16'h0f0f,16'h0,5'h10,1'h0,1'h0,4'h3,1'h0,4'h3},
      '{24'h500050,1'h0,1'h0,16'h0,16'h0f0f,5'h10,1'h0,1'h0,4'h3,1'h0,4'h3},
      '{24'h210060,1'h1,1'h0,16'h4321,16'h0,5'h01,1'h1,1'h0,4'h0,1'h0,4'h1},
      '{24'h210060,1'h0,1'h0,16'h0,16'h4321,5'h01,1'h1,1'h0,4'h0,1'h0,4'h1},
      '{24'hf00070,1'h1,1'h0,16'h9876,16'h0,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'hf00070,1'h0,1'h0,16'h0,16'h9876,5'h01,1'h0,1'h0,4'h0,1'h0,4'h1},
      '{24'h200082,1'h0,1'h0,16'h0,16'h5a82,5'h00,1'h0,1'h0,4'h0,1'h0,4'h0}
   };
   // Clocks, the link one offset in phase
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end
   // Watch what one access puts on the pins
   always @(negedge link_clk) cs_seen = cs_seen | ~cs_n;
   always @(negedge link_clk) aen_seen = aen_seen | addr_en;
   always @(negedge refclk) if (!rd_n || !wr_n) stb_cnt++;
   always @(negedge clk) ph_seen = ph_seen | pipe_hold;
   always @(negedge link_clk) if (ad_oe && !rd_n) chk("ad_oe", 24'h0, 24'h1);
   ebw_ctrl i_dut (.clk_i(clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
      .req_i(req), .req_addr_i(req_addr), .req_wr_i(req_wr),
      .req_byte_i(req_byte), .req_wdata_i(req_wdata), .busy_o(busy),
      .done_o(done), .err_o(err), .rdata_o(rdata), .pipe_hold_o(pipe_hold),
      .ext_mode_i(ext_mode), .addr_width_i(addr_width),
      .seg_lines_i(seg_lines), .win_en_i(win_en), .win_base_i(win_base),
      .win_mask_i(win_mask), .region_timing_i(region_timing),
      .region_function_i(region_function),
      .bus_reference_clock_out_o(refclk), .addr_o(addr),
      .addr_en_o(addr_en), .ad_i(ad_in), .ad_o(ad_out), .ad_oe_o(ad_oe),
      .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n), .bhe_n_o(bhe_n),
      .cs_n_o(cs_n), .ready_i(ready), .ipb_sel_o(ipb_sel),
      .ipb_wr_o(ipb_wr), .ipb_addr_o(ipb_addr), .ipb_wdata_o(ipb_wdata),
      .ipb_rdata_i(ipb_rdata), .ipb_rdy_i(ipb_rdy));
   ebw_mem_model i_mem (.ref_clk_i(refclk), .addr_i(addr),
      .addr_en_i(addr_en), .ad_i(ad_out), .ale_i(ale), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .bhe_n_i(bhe_n), .narrow_i(narrow), .rdy_hi_i(rdy_hi),
      .wait_i(wt), .ad_o(ad_in), .ready_o(ready), .ipb_sel_i(ipb_sel),
      .ipb_addr_i(ipb_addr), .ipb_rdata_o(ipb_rdata), .ipb_rdy_o(ipb_rdy));
   // One compare, counted
   task automatic chk(input string nm, input logic [23:0] ex,
                      input logic [23:0] got);
      n_tests++;
      if (got !== ex) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // One request, entered and left at a falling edge
   task automatic acc(input ebw_tb_row_type r);
      int n;
      n = 0;
      narrow = r.nr;
      rdy_hi = r.rh;
      wt = r.wt;
      cs_seen = 5'h00;
      aen_seen = '0;
      stb_cnt = 0;
      ph_seen = 1'b0;
      req_addr = r.a;
      req_wr = r.wr;
      req_byte = r.by;
      req_wdata = r.wd;
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk("done", 24'h1, {23'h0, done});
      rd = rdata;
      e = err;
      @(negedge clk);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      error_cnt++;
      $display("ERROR watchdog expired");
      give_verdict();
   end
   // Set up, reset, rows, then hand tests
   initial begin
      {rst_n, req, req_wr, req_byte, narrow, rdy_hi} = 6'h00;
      {req_addr, req_wdata, wt, ext_mode} = 45'h1;
      addr_width = 5'h18;
      seg_lines = 3'h7;
      win_en = 4'hf;
      win_base = {12'h500, 12'h500, 12'h410, 12'h400};
      win_mask = {12'hf00, 12'hf00, 12'hff0, 12'hf00};
      region_timing = {8'h00, 8'h00, 8'h44, 8'h00, 8'h00};
      region_function = {5'h15, 5'h14, 5'h1f, 5'h18, 5'h14};
      repeat (12) @(negedge clk);
      chk("cs_n in reset", 24'h1f, {19'h0, cs_n});
      rst_n = 1'b1;
      @(negedge clk);
      foreach (rows[i]) begin
         acc(rows[i]);
         if (!rows[i].wr) chk("rdata", {8'h0, rows[i].rd}, {8'h0, rd});
         chk("cs seen", {19'h0, rows[i].cs}, {19'h0, cs_seen});
         chk("pipe hold", {23'h0, rows[i].ph}, {23'h0, ph_seen});
         chk("err", 24'h0, {23'h0, e});
         if (stb_cnt < int'(rows[i].mn)) chk("strobe ticks", 24'h1, 24'h0);
         $display("row %0d done", i);
      end
      ext_mode = 1'b0;
      acc(rows[1]);
      chk("single chip err", 24'h1, {23'h0, e});
      chk("single chip cs", 24'h0, {19'h0, cs_seen});
      ext_mode = 1'b1;
      addr_width = 5'h08;
      acc(rows[1]);
      chk("addr lines 8", 24'h0, {8'h0, aen_seen[23:8]});
      addr_width = 5'h18;
      seg_lines = 3'h0;
      acc(rows[1]);
      chk("seg lines 0", 24'h0, {16'h0, aen_seen[23:16]});
      seg_lines = 3'h7;
      acc(rows[8]);
      chk("seg line 22", 24'h1, {23'h0, aen_seen[22]});
      acc('{24'h200084,1'h1,1'h0,16'h55aa,16'h0,5'h0,1'h0,1'h0,4'h0,1'h0,4'h0});
      chk("ipb wdata", 24'h55aa, {8'h0, ipb_wdata});
      chk("ipb wr", 24'h1, {23'h0, ipb_wr});
      $display("config tests done");
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      chk("cs_n mid reset", 24'h1f, {19'h0, cs_n});
      chk("strobes mid reset", 24'hc, {20'h0, rd_n, wr_n, ale, busy});
      rst_n = 1'b1;
      @(negedge clk);
      acc(rows[4]);
      chk("rdata after reset", 24'h7734, {8'h0, rd});
      $display("reset test done");
      give_verdict();
   end
endmodule
